/* File: design/rtc_pkg.sv */
/*
  Package for the periodic pattern timer and calendar clockwatch block: register
  offsets, field positions, reset values and carrier types.
  Assumes a single 10 MHz clock and a synchronous active-low reset.
*/
package rtc_pkg;
  localparam logic [7:0]  RTC_OFF_CTRL     = 8'h00;
  localparam logic [7:0]  RTC_OFF_RELOAD1  = 8'h04;
  localparam logic [7:0]  RTC_OFF_RELOAD2  = 8'h08;
  localparam logic [7:0]  RTC_OFF_PATTERN  = 8'h0C;
  localparam logic [7:0]  RTC_OFF_COUNT    = 8'h10;
  localparam logic [7:0]  RTC_OFF_CW_TIME  = 8'h14;
  localparam logic [7:0]  RTC_OFF_CW_DATE  = 8'h18;
  localparam logic [7:0]  RTC_OFF_MT_TIME  = 8'h1C;
  localparam logic [7:0]  RTC_OFF_MT_DATE  = 8'h20;
  localparam logic [7:0]  RTC_OFF_STATUS   = 8'h24;
  localparam logic [7:0]  RTC_OFF_MASK     = 8'h28;
  localparam logic [7:0]  RTC_OFF_CW_LOAD  = 8'h2C;

  localparam int          RTC_CTRL_TMR_EN  = 0;
  localparam int          RTC_CTRL_PAT_EN  = 1;
  localparam int          RTC_CTRL_CW_EN   = 2;
  localparam int          RTC_CTRL_PLEN_LO = 4;
  localparam int          RTC_ST_TMR       = 0;
  localparam int          RTC_ST_MATCH     = 1;

  localparam logic [31:0] RTC_RELOAD_RST   = 32'h0000_0000;
  localparam logic [7:0]  RTC_PATTERN_RST  = 8'h00;
  localparam logic [2:0]  RTC_PLEN_RST     = 3'h7;

  // Clockwatch second tick: 1 s at 10 MHz.
  localparam int          RTC_CLK_HZ       = 10_000_000;
  localparam int          RTC_TICK_S       = 1;
  localparam int          RTC_SEC_CYCLES   = RTC_CLK_HZ * RTC_TICK_S;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtc_datetime_t;

  localparam rtc_datetime_t RTC_DT_RST = '{year: 7'h00, month: 4'h1, day: 5'h01,
                                           hour: 5'h00, minute: 6'h00, second: 6'h00};
endpackage

/* File: design/rtc_pattern_timer.sv */
/*
  Periodic down-counter with two reload values chosen by a repeating bit pattern.
  Assumes configuration is stable from the register file on the same clock.
*/
module rtc_pattern_timer
  import rtc_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             pat_en,
  input  wire logic [2:0]       pat_last,
  input  wire logic [7:0]       pattern,
  input  wire logic [WIDTH-1:0] reload1,
  input  wire logic [WIDTH-1:0] reload2,
  output logic      [WIDTH-1:0] count,
  output logic                  zero_evt
);
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic [2:0]       idx_q, idx_d;
  logic             en_q, en_d;
  logic             evt_q, evt_d;

  always_comb begin
    cnt_d = cnt_q;
    idx_d = idx_q;
    evt_d = 1'b0;
    en_d  = enable;
    if (!enable) begin
      idx_d = 3'h0;
    end else if (!en_q) begin
      cnt_d = (pat_en && !pattern[7]) ? reload2 : reload1;
    end else if (cnt_q == '0) begin
      evt_d = 1'b1;
      if (pat_en) begin
        idx_d = (idx_q == pat_last) ? 3'h0 : idx_q + 3'h1;
        cnt_d = pattern[3'h7 - idx_d] ? reload1 : reload2;
      end else begin
        cnt_d = reload1;
      end
    end else begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      idx_q <= 3'h0;
      en_q  <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      en_q  <= en_d;
      evt_q <= evt_d;
    end
  end

  assign count    = cnt_q;
  assign zero_evt = evt_q;
endmodule

/* File: design/rtc_clockwatch.sv */
/*
  Calendar clockwatch: counts seconds through years and flags a match.
  Assumes a one-cycle load strobe and years counted from 2000.
*/
module rtc_clockwatch
  import rtc_pkg::*;
#(
  parameter int SEC_CYCLES = RTC_SEC_CYCLES
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          enable,
  input  wire logic          load,
  input  wire rtc_datetime_t load_val,
  input  wire rtc_datetime_t match_val,
  output rtc_datetime_t      now,
  output logic               match_evt
);
  rtc_datetime_t now_q, now_d;
  logic [31:0]   pre_q, pre_d;
  logic          evt_q, evt_d;
  logic          tick;
  logic [4:0]    dim;

  always_comb begin
    case (now_q.month)
      4'h2:                      dim = (now_q.year[1:0] == 2'h0) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB:    dim = 5'd30;
      default:                   dim = 5'd31;
    endcase
  end

  always_comb begin
    now_d = now_q;
    pre_d = pre_q;
    evt_d = 1'b0;
    tick  = 1'b0;
    if (load) begin
      now_d = load_val;
      pre_d = '0;
    end else if (enable) begin
      if (pre_q == 32'(SEC_CYCLES - 1)) begin
        pre_d = '0;
        tick  = 1'b1;
      end else begin
        pre_d = pre_q + 32'h1;
      end
    end
    if (tick) begin
      now_d.second = now_q.second + 6'h1;
      if (now_q.second == 6'd59) begin
        now_d.second = 6'h0;
        now_d.minute = now_q.minute + 6'h1;
        if (now_q.minute == 6'd59) begin
          now_d.minute = 6'h0;
          now_d.hour   = now_q.hour + 5'h1;
          if (now_q.hour == 5'd23) begin
            now_d.hour = 5'h0;
            now_d.day  = now_q.day + 5'h1;
            if (now_q.day == dim) begin
              now_d.day   = 5'h1;
              now_d.month = now_q.month + 4'h1;
              if (now_q.month == 4'd12) begin
                now_d.month = 4'h1;
                now_d.year  = now_q.year + 7'h1;
              end
            end
          end
        end
      end
      evt_d = (now_d == match_val);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      now_q <= RTC_DT_RST;
      pre_q <= '0;
      evt_q <= 1'b0;
    end else begin
      now_q <= now_d;
      pre_q <= pre_d;
      evt_q <= evt_d;
    end
  end

  assign now       = now_q;
  assign match_evt = evt_q;
endmodule

/* File: design/rtc_top.sv */
/*
  Top of the periodic pattern timer and calendar clockwatch block, with its
  register file, sticky status, mask and one level interrupt.
  Assumes a plain register port with read data one cycle after the read strobe.
*/
// Design decisions made here: the register addresses and the strobed register port.
// What this block does
// - Reaching zero interrupts and reloads first value.
// - Pattern bit picks first or second reload.
// - Pattern length is configurable up to eight.
// - Pattern restarts after last bit, repeating.
// - Clockwatch keeps date and time, software-loadable.
// - Clockwatch equal to match raises interrupt.
// - Timer and clockwatch run independently.
module rtc_top
  import rtc_pkg::*;
#(
  parameter int WIDTH      = 32,
  parameter int SEC_CYCLES = RTC_SEC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq
);
  logic [31:0]      ctrl_q, ctrl_d;
  logic [WIDTH-1:0] rl1_q, rl1_d, rl2_q, rl2_d;
  logic [7:0]       pat_q, pat_d;
  rtc_datetime_t    mt_q, mt_d, ld_q, ld_d;
  logic [1:0]       st_q, st_d, mask_q, mask_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             irq_q, irq_d;
  logic             cw_load;
  logic [WIDTH-1:0] count;
  logic             tmr_evt, match_evt;
  rtc_datetime_t    now;

  // The timer and the clockwatch are separate instances with separate events.
  rtc_pattern_timer #(.WIDTH(WIDTH)) u_timer (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .enable   (ctrl_q[RTC_CTRL_TMR_EN]),
    .pat_en   (ctrl_q[RTC_CTRL_PAT_EN]),
    .pat_last (ctrl_q[RTC_CTRL_PLEN_LO +: 3]),
    .pattern  (pat_q),
    .reload1  (rl1_q),
    .reload2  (rl2_q),
    .count    (count),
    .zero_evt (tmr_evt)
  );

  rtc_clockwatch #(.SEC_CYCLES(SEC_CYCLES)) u_cw (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .enable    (ctrl_q[RTC_CTRL_CW_EN]),
    .load      (cw_load),
    .load_val  (ld_q),
    .match_val (mt_q),
    .now       (now),
    .match_evt (match_evt)
  );

  always_comb begin
    ctrl_d  = ctrl_q;
    rl1_d   = rl1_q;
    rl2_d   = rl2_q;
    pat_d   = pat_q;
    mt_d    = mt_q;
    ld_d    = ld_q;
    mask_d  = mask_q;
    st_d    = st_q;
    cw_load = 1'b0;
    if (wr) begin
      case (addr)
        RTC_OFF_CTRL:    ctrl_d = {25'h0, wdata[6:4], 1'b0, wdata[2:0]};
        RTC_OFF_RELOAD1: rl1_d  = wdata[WIDTH-1:0];
        RTC_OFF_RELOAD2: rl2_d  = wdata[WIDTH-1:0];
        RTC_OFF_PATTERN: pat_d  = wdata[7:0];
        RTC_OFF_CW_TIME: ld_d   = {ld_q[32:17], wdata[16:0]};
        RTC_OFF_CW_DATE: ld_d   = {wdata[15:0], ld_q[16:0]};
        RTC_OFF_MT_TIME: mt_d   = {mt_q[32:17], wdata[16:0]};
        RTC_OFF_MT_DATE: mt_d   = {wdata[15:0], mt_q[16:0]};
        RTC_OFF_MASK:    mask_d = wdata[1:0];
        RTC_OFF_STATUS:  st_d   = st_q & ~wdata[1:0];
        RTC_OFF_CW_LOAD: cw_load = wdata[0];
        default:         ctrl_d = ctrl_q;
      endcase
    end
    if (tmr_evt) begin
      st_d[RTC_ST_TMR] = 1'b1;
    end
    if (match_evt) begin
      st_d[RTC_ST_MATCH] = 1'b1;
    end
    irq_d   = |(st_d & mask_d);
    rdata_d = 32'h0;
    if (rd) begin
      case (addr)
        RTC_OFF_CTRL:    rdata_d = ctrl_q;
        RTC_OFF_RELOAD1: rdata_d = 32'(rl1_q);
        RTC_OFF_RELOAD2: rdata_d = 32'(rl2_q);
        RTC_OFF_PATTERN: rdata_d = {24'h0, pat_q};
        RTC_OFF_COUNT:   rdata_d = 32'(count);
        RTC_OFF_CW_TIME: rdata_d = {15'h0, now[16:0]};
        RTC_OFF_CW_DATE: rdata_d = {16'h0, now[32:17]};
        RTC_OFF_MT_TIME: rdata_d = {15'h0, mt_q[16:0]};
        RTC_OFF_MT_DATE: rdata_d = {16'h0, mt_q[32:17]};
        RTC_OFF_STATUS:  rdata_d = {30'h0, st_q};
        RTC_OFF_MASK:    rdata_d = {30'h0, mask_q};
        default:         rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q  <= {25'h0, RTC_PLEN_RST, 4'h0};
      rl1_q   <= RTC_RELOAD_RST[WIDTH-1:0];
      rl2_q   <= RTC_RELOAD_RST[WIDTH-1:0];
      pat_q   <= RTC_PATTERN_RST;
      mt_q    <= RTC_DT_RST;
      ld_q    <= RTC_DT_RST;
      mask_q  <= 2'h0;
      st_q    <= 2'h0;
      rdata_q <= 32'h0;
      irq_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      rl1_q   <= rl1_d;
      rl2_q   <= rl2_d;
      pat_q   <= pat_d;
      mt_q    <= mt_d;
      ld_q    <= ld_d;
      mask_q  <= mask_d;
      st_q    <= st_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign irq   = irq_q;
endmodule

/* File: tb/rtc_props.sv */
/*
  Checker for rtc_top: concurrent properties on the register port and interrupt.
  Assumes one clock domain and that it is bound to every instance of rtc_top.
*/
module rtc_props
  import rtc_pkg::*;
#(
  parameter int WIDTH      = 32,
  parameter int SEC_CYCLES = RTC_SEC_CYCLES
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq
);
  logic [6:0]  sh_ctrl_q;
  logic [31:0] sh_rl1_q;
  logic [1:0]  sh_mask_q;
  logic [1:0]  mzero_q;

  // Shadow copies of the control, first reload and mask registers written over the port.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sh_ctrl_q <= 7'h70;
      sh_rl1_q  <= RTC_RELOAD_RST;
      sh_mask_q <= 2'h0;
      mzero_q   <= 2'h0;
    end else begin
      if (wr && addr == RTC_OFF_CTRL) sh_ctrl_q <= wdata[6:0];
      if (wr && addr == RTC_OFF_RELOAD1) sh_rl1_q <= wdata;
      if (wr && addr == RTC_OFF_MASK) sh_mask_q <= wdata[1:0];
      if (sh_mask_q != 2'h0) mzero_q <= 2'h0;
      else if (mzero_q != 2'h3) mzero_q <= mzero_q + 2'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_cnt_pair;
    rd && addr == RTC_OFF_COUNT ##1 rd && addr == RTC_OFF_COUNT;
  endsequence

  property p_rdata_idle;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_unmapped;
    rd && addr == 8'h30 |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reload_rb;
    rd && addr == RTC_OFF_RELOAD1 |=> rdata == sh_rl1_q;
  endproperty
  a_reload_rb: assert property (p_reload_rb) else $error("reload readback");
  property p_ctrl_rb;
    rd && addr == RTC_OFF_CTRL |=> {rdata[6:4], rdata[2:0]} == {sh_ctrl_q[6:4], sh_ctrl_q[2:0]};
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback");
  property p_mask_rb;
    rd && addr == RTC_OFF_MASK |=> rdata[1:0] == sh_mask_q;
  endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("mask readback");
  property p_mask_quiet;
    mzero_q == 2'h3 |-> !irq;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("irq while all masked");
  property p_count_hold;
    !sh_ctrl_q[RTC_CTRL_TMR_EN] ##0 s_cnt_pair |=> $stable(rdata);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved while off");
  property p_count_step;
    sh_ctrl_q[RTC_CTRL_TMR_EN] && $past(sh_ctrl_q[RTC_CTRL_TMR_EN])
      && !sh_ctrl_q[RTC_CTRL_PAT_EN] ##0 s_cnt_pair
      |=> rdata == (($past(rdata) == 32'h0) ? sh_rl1_q : $past(rdata) - 32'h1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");
endmodule

bind rtc_top rtc_props #(.WIDTH(WIDTH), .SEC_CYCLES(SEC_CYCLES)) u_props (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq));

/* File: tb/rtc_periodic_pattern_timer_test.sv */
/*
  Self-checking bench for rtc_top, one task for each scenario.
  Assumes the checker is bound and the second tick is shortened to 10 cycles.
*/
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t ns: got %0h expected %0h", $time, (g), (e)); end end
module rtc_periodic_pattern_timer_test;
  import rtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  logic [31:0] d1;
  logic [31:0] d2;
  int          failures = 0;
  int          samples_checked = 0;
  int          n;
  time         rise_at = 0;

  rtc_top #(.WIDTH(32), .SEC_CYCLES(10)) dut (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk); wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk); rd <= 1'b1; addr <= a;
    @(posedge mclk); rd <= 1'b0;
    @(negedge mclk); d = rdata;
  endtask
  task rd2(input logic [7:0] a, output logic [31:0] r1, output logic [31:0] r2);
    @(posedge mclk); rd <= 1'b1; addr <= a;
    @(posedge mclk); @(negedge mclk); r1 = rdata;
    @(posedge mclk); rd <= 1'b0;
    @(negedge mclk); r2 = rdata;
  endtask
  // Waits on falling edges, so irq is always looked at where it is settled.
  task wait_lvl(input logic l, output int k);
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (irq !== l && k < 2000);
    if (irq !== l) begin
      failures++;
      $display("wrong value at %0t ns: irq wait ran out", $time);
    end
  endtask
  // Cycles from the previous rise of irq to the next one, clearing the timer status first.
  task measure(output int c);
    int k;
    wr_reg(RTC_OFF_STATUS, 32'h1);
    wait_lvl(1'b0, k);
    wait_lvl(1'b1, k);
    c = int'(($time - rise_at) / 100);
    rise_at = $time;
  endtask

  task t_reset;
    rd_reg(RTC_OFF_CTRL, d1);
    `CHK(d1, 32'h0000_0070)
    rd_reg(RTC_OFF_RELOAD1, d1);
    `CHK(d1, RTC_RELOAD_RST)
    rd_reg(RTC_OFF_MASK, d1);
    `CHK(d1, 32'h0)
    rd_reg(8'h30, d1);
    `CHK(d1, 32'h0)
    rd_reg(RTC_OFF_CW_DATE, d1);
    `CHK(d1, 32'h0000_0021)
    $display("done reset");
  endtask
  task t_timer;
    int c;
    wr_reg(RTC_OFF_RELOAD1, 32'h0000_0013);
    wr_reg(RTC_OFF_MASK, 32'h1);
    wr_reg(RTC_OFF_CTRL, 32'h0000_0071);
    rd2(RTC_OFF_COUNT, d1, d2);
    `CHK(d2, d1 - 32'h1)
    measure(c);
    repeat (2) begin
      measure(c);
      `CHK(c, 20)
    end
    wr_reg(RTC_OFF_CTRL, 32'h0000_0070);
    rd2(RTC_OFF_COUNT, d1, d2);
    `CHK(d2, d1)
    $display("done timer");
  endtask
  task t_pattern(input logic [7:0] p, input logic [2:0] last, input int k);
    int c;
    int b;
    wr_reg(RTC_OFF_RELOAD1, 32'h0000_001D);
    wr_reg(RTC_OFF_RELOAD2, 32'h0000_0009);
    wr_reg(RTC_OFF_PATTERN, {24'h0, p});
    wr_reg(RTC_OFF_STATUS, 32'h3);
    wr_reg(RTC_OFF_CTRL, {25'h0, last, 4'h3});
    measure(c);
    b = 7;
    repeat (k) begin
      b = (b == 7 - last) ? 7 : b - 1;
      measure(c);
      `CHK(c, p[b] ? 30 : 10)
    end
    wr_reg(RTC_OFF_CTRL, 32'h0000_0070);
    wr_reg(RTC_OFF_STATUS, 32'h3);
    $display("done pattern %0h", p);
  endtask
  task t_clock;
    wr_reg(RTC_OFF_CW_TIME, 32'h0001_7EFA);
    wr_reg(RTC_OFF_CW_DATE, 32'h0000_1D9F);
    wr_reg(RTC_OFF_CW_LOAD, 32'h1);
    wr_reg(RTC_OFF_MT_TIME, 32'h1);
    wr_reg(RTC_OFF_MT_DATE, 32'h0000_1E21);
    wr_reg(RTC_OFF_RELOAD1, 32'h4);
    rd_reg(RTC_OFF_CW_TIME, d1);
    `CHK(d1, 32'h0001_7EFA)
    wr_reg(RTC_OFF_MASK, 32'h2);
    wr_reg(RTC_OFF_CTRL, 32'h0000_0075);
    wait_lvl(1'b1, n);
    `CHK(n, 3 * 10 + 2)
    rd_reg(RTC_OFF_CW_DATE, d1);
    `CHK(d1, 32'h0000_1E21)
    rd_reg(RTC_OFF_CW_TIME, d1);
    `CHK(d1, 32'h1)
    rd_reg(RTC_OFF_STATUS, d1);
    `CHK(d1, 32'h3)
    wr_reg(RTC_OFF_STATUS, 32'h3);
    repeat (3) @(negedge mclk);
    `CHK(irq, 1'b0)
    wr_reg(RTC_OFF_CTRL, 32'h0000_0070);
    $display("done clockwatch");
  endtask

  task give_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_pattern(8'hF2, 3'h7, 10);
    t_pattern(8'hA0, 3'h2, 5);
    t_clock();
    give_verdict();
  end
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule
